// ### bench/host_model.sv
// host-side model: card clock, select and data lines toward the card
module host_model (
	input wire logic clk_i,
	input wire logic busy_i,
	output logic card_clk_o,
	output logic sel_n_o,
	output logic serial_o,
	output logic [3:0] dat_o,
	output logic dat_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// lines idle: clock still, select high, data released
	initial begin
		{card_clk_o, sel_n_o, serial_o, dat_o, dat_oe_o} = 8'h7E;
	end

	// one frame of 32 bits, a bit or a nibble per card clock rise, 8 system cycles a period
	task automatic send(input logic [31:0] d, input int step);
		int k;
		k = 0;
		// no data while the card holds the line low
		while (busy_i !== 1'b1 && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		for (int u = 0; u < 32 / step; u++) begin
			// data changes on the falling card clock edge
			@(posedge clk_i) begin
				card_clk_o <= 1'b0;
				sel_n_o <= 1'b0;
				dat_oe_o <= 1'b1;
				dat_o <= (step == 4) ? d[31:28] : {3'h7, d[31]};
				serial_o <= d[31];
			end
			d = d << step;
			repeat (4) @(posedge clk_i);
			card_clk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
		// release the data lines; the clock stands still between frames
		@(posedge clk_i) begin
			card_clk_o <= 1'b0;
			dat_oe_o <= 1'b0;
			serial_o <= ~serial_o;
		end
	endtask
endmodule // host_model

// ### bench/tb_card_bus_engine.sv
// self-checking bench for the card-side bus engine
module tb_card_bus_engine;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int BB = 4; // short blocks
	localparam int PC = 300; // programming outlasts a 4-bit block
	logic clk, rst, init_done, wr_start, multi, stop, tx_en, tx_bit;
	logic [1:0] mode, bufs;
	logic card_clk, sel_n, ser_in, h_oe, busy_line;
	logic [3:0] h_dat, dat_w, dat_o, dat_oe;
	logic ser_out, ser_oe, cmd_o, cmd_oe, cmd_rx, pp, rcv, busy, blk_done, prog_done, rx_valid;
	logic [7:0] rx_byte;
	logic [31:0] seed;
	logic [7:0] rxq[$], expq[$];
	int miscompares = 0, check_count = 0, cyc = 0, nblk = 0, nprog = 0;

	card_bus_engine #(.BLOCK_BYTES(BB), .NUM_BUFS(2), .PROG_CYCLES(PC)) DUT (.CLK_I(clk), .RST_I(rst),
		.CARD_CLK_I(card_clk), .SEL_N_I(sel_n), .SERIAL_IN_I(ser_in), .SERIAL_OUT_O(ser_out),
		.SERIAL_OUT_OE_O(ser_oe), .CMD_I(cmd_oe ? cmd_o : 1'b1), .CMD_O(cmd_o), .CMD_OE_O(cmd_oe),
		.DAT_I(dat_w), .DAT_O(dat_o), .DAT_OE_O(dat_oe), .BUS_MODE_I(mode), .INIT_DONE_I(init_done),
		.WR_START_I(wr_start), .MULTI_BLOCK_I(multi), .STOP_I(stop), .CMD_TX_EN_I(tx_en),
		.CMD_TX_BIT_I(tx_bit), .CMD_RX_O(cmd_rx), .PUSH_PULL_O(pp), .RECEIVING_O(rcv), .BUSY_O(busy),
		.BUFS_USED_O(bufs), .BLOCK_DONE_O(blk_done), .PROG_DONE_O(prog_done), .RX_BYTE_O(rx_byte),
		.RX_BYTE_VALID_O(rx_valid));
	host_model host (.clk_i(clk), .busy_i(busy_line), .card_clk_o(card_clk), .sel_n_o(sel_n),
		.serial_o(ser_in), .dat_o(h_dat), .dat_oe_o(h_oe));

	// wire levels: card enables win, released lines pulled up
	assign dat_w = (dat_oe & dat_o) | (~dat_oe & (h_oe ? h_dat : 4'hF));
	assign busy_line = (mode == 2'h0) ? ser_out : dat_w[0];

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// byte collector and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) rxq.push_back(rx_byte);
		if (blk_done === 1'b1) nblk++;
		if (prog_done === 1'b1) nprog++;
		if (cyc == 30000) begin
			miscompares++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	// command line enable: only low is driven before push-pull
	function automatic logic exp_oe(input logic p, input logic b);
		return p | ~b;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one write: n random blocks, busy and line checked after each
	task automatic xfer(input logic [1:0] m, input logic mb, input int n);
		int b0, p0;
		b0 = nblk;
		p0 = nprog;
		@(posedge clk) begin
			mode <= m;
			wr_start <= 1'b1;
			multi <= mb;
		end
		@(posedge clk) wr_start <= 1'b0;
		#1 check("receiving", rcv, 1'b1);
		for (int b = 0; b < n; b++) begin
			seed = xs(seed);
			for (int j = 3; j >= 0; j--) expq.push_back(seed[j*8 +: 8]);
			host.send(seed, (m == 2'h2) ? 4 : 1);
			repeat (4) @(posedge clk);
			#1 check("busy", busy, !mb || b > 0);
			check("line", busy_line, mb && b == 0);
			check("line_oe", (m == 2'h0) ? ser_oe : dat_oe[0], !mb || b > 0);
			check("open", rcv, mb);
		end
		if (mb) begin
			@(posedge clk) stop <= 1'b1;
			@(posedge clk) stop <= 1'b0;
			#1 check("stopped", rcv, 1'b0);
		end
		for (int k = 0; k < 4 * (PC + 2) && busy !== 1'b0; k++) @(posedge clk);
		#1 check("bufs", bufs, 0);
		check("blocks", nblk - b0, n);
		check("programmed", nprog - p0, n);
		check("nbytes", rxq.size(), expq.size());
		while (expq.size() > 0 && rxq.size() > 0) check("rx_byte", rxq.pop_front(), expq.pop_front());
	endtask

	// supply off and on again: reset held three cycles, lines checked at release
	task automatic power_cycle();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tx_en <= 1'b1;
		#1 check("rst_lines", {dat_oe, ser_out, cmd_oe, cmd_o, busy, pp, bufs}, 11'h050);
	endtask

	task automatic complete_run();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, init_done, wr_start, multi, stop, tx_en, tx_bit, mode} = 9'h100;
		seed = 32'h36F65374;
		power_cycle();
		// command line drive before and after push-pull
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				@(posedge clk) init_done <= 1'b1;
				@(posedge clk) init_done <= 1'b0;
			end
			@(posedge clk) tx_bit <= i[0];
			@(posedge clk);
			#1 check("cmd_oe", cmd_oe, exp_oe(i >= 2, i[0]));
			check("push_pull", pp, i >= 2);
		end
		// command line read back through the pin synchroniser
		@(posedge clk) tx_bit <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check("cmd_o", cmd_o, 1'b0);
		check("cmd_rx", cmd_rx, 1'b0);
		for (int m = 0; m < 3; m++) xfer(m[1:0], 1'b0, 1);
		// power removed and reapplied mid-run, then initialization again
		@(posedge clk);
		power_cycle();
		@(posedge clk) init_done <= 1'b1;
		@(posedge clk) init_done <= 1'b0;
		#1 check("reinit", pp, 1'b1);
		xfer(2'h2, 1'b1, 3);
		complete_run();
	end
endmodule // tb_card_bus_engine

// ### rtl/card_bus_engine.sv
// card-side bus engine: pin drive, block reception, buffers and busy
`include "card_regs.svh"

module card_bus_engine #(
	parameter int BLOCK_BYTES = `CARD_BLOCK_BYTES,
	parameter int NUM_BUFS = `CARD_NUM_BUFS,
	parameter int PROG_CYCLES = `CARD_PROG_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CARD_CLK_I,
	input wire logic SEL_N_I,
	input wire logic SERIAL_IN_I,
	output logic SERIAL_OUT_O,
	output logic SERIAL_OUT_OE_O,
	input wire logic CMD_I,
	output logic CMD_O,
	output logic CMD_OE_O,
	input wire logic [`CARD_DAT_WIDTH-1:0] DAT_I,
	output logic [`CARD_DAT_WIDTH-1:0] DAT_O,
	output logic [`CARD_DAT_WIDTH-1:0] DAT_OE_O,
	input wire logic [1:0] BUS_MODE_I,
	input wire logic INIT_DONE_I,
	input wire logic WR_START_I,
	input wire logic MULTI_BLOCK_I,
	input wire logic STOP_I,
	input wire logic CMD_TX_EN_I,
	input wire logic CMD_TX_BIT_I,
	output logic CMD_RX_O,
	output logic PUSH_PULL_O,
	output logic RECEIVING_O,
	output logic BUSY_O,
	output logic [$clog2(NUM_BUFS+1)-1:0] BUFS_USED_O,
	output logic BLOCK_DONE_O,
	output logic PROG_DONE_O,
	output logic [`CARD_BYTE_BITS-1:0] RX_BYTE_O,
	output logic RX_BYTE_VALID_O
);

	// ----------------------------------------------------------------
	// local sizes
	// ----------------------------------------------------------------
	localparam int BUF_W = $clog2(NUM_BUFS+1);
	localparam int CNT_W = $clog2(BLOCK_BYTES*`CARD_BYTE_BITS+1) + 1;
	localparam int PCNT_W = $clog2(PROG_CYCLES+1);
	localparam logic [CNT_W-1:0] BLOCK_BITS = CNT_W'(BLOCK_BYTES*`CARD_BYTE_BITS);
	localparam logic [BUF_W-1:0] BUFS_FULL = BUF_W'(NUM_BUFS);
	localparam logic [PCNT_W-1:0] PROG_LAST = PCNT_W'(PROG_CYCLES-1);

	// ----------------------------------------------------------------
	// pin synchronisers and link clock edge
	// ----------------------------------------------------------------
	logic [`CARD_SYNC_WIDTH-1:0] pin_meta; // first stage, read only by second
	logic [`CARD_SYNC_WIDTH-1:0] pin_sync; // second stage
	logic cclk_prev; // last synced link clock level

	// both stages run every rising clock edge; pins come from the host domain
	always_ff @(posedge CLK_I) begin
		pin_meta <= {CARD_CLK_I, SEL_N_I, SERIAL_IN_I, CMD_I, DAT_I};
		pin_sync <= pin_meta;
		cclk_prev <= pin_sync[7];
	end

	wire logic cclk_s = pin_sync[7];
	wire logic sel_n_s = pin_sync[6];
	wire logic si_s = pin_sync[5];
	wire logic cmd_s = pin_sync[4];
	wire logic [`CARD_DAT_WIDTH-1:0] dat_s = pin_sync[3:0];
	wire logic cclk_rise = cclk_s & ~cclk_prev;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	card_pkg::rx_state_t rx_state; // reception of write data
	card_pkg::prog_state_t prog_state; // flash programming
	logic multi; // latched block mode of current command
	logic push_pull; // set once initialization has finished
	logic [CNT_W-1:0] bit_cnt; // bits of current block received
	logic [BUF_W-1:0] bufs_used; // full internal buffers
	logic [PCNT_W-1:0] prog_cnt; // cycles left of programming
	logic [`CARD_BYTE_BITS-1:0] shreg; // byte assembly

	// ----------------------------------------------------------------
	// decode of mode, sample and acceptance
	// ----------------------------------------------------------------
	wire card_pkg::bus_mode_t bus_mode = card_pkg::bus_mode_t'(BUS_MODE_I);
	wire logic mode_spi = (bus_mode == card_pkg::MODE_SPI);
	wire logic mode_nat4 = (bus_mode == card_pkg::MODE_NAT4);
	wire logic selected = mode_spi & ~sel_n_s;
	wire logic line_bit = mode_spi ? si_s : dat_s[0];
	wire logic [CNT_W-1:0] step = mode_nat4 ? CNT_W'(`CARD_STEP_4BIT) : CNT_W'(`CARD_STEP_1BIT);
	// data taken only while a buffer is free; a host ignoring busy is refused
	wire logic accept = cclk_rise & (rx_state == card_pkg::RX_RECV) & (bufs_used != BUFS_FULL)
		& (~mode_spi | selected);
	wire logic [CNT_W-1:0] next_cnt = bit_cnt + step;
	// a stop in the same cycle drops the block, so no buffer is claimed for it
	wire logic block_done = accept & ~STOP_I & (next_cnt >= BLOCK_BITS);
	wire logic byte_done = accept & (next_cnt[2:0] == 3'h0);
	wire logic [`CARD_BYTE_BITS-1:0] next_shreg = mode_nat4 ? {shreg[3:0], dat_s} : {shreg[6:0], line_bit};
	wire logic prog_done = (prog_state == card_pkg::PROG_RUN) & (prog_cnt == '0);
	wire logic [BUF_W-1:0] next_bufs = bufs_used + BUF_W'(block_done) - BUF_W'(prog_done);
	// multi-block stays free while receiving with any buffer empty; single-block busy at once
	wire logic busy_cond = (bufs_used == BUFS_FULL)
		| ((bufs_used != '0) & ~((rx_state == card_pkg::RX_RECV) & multi));

	// ----------------------------------------------------------------
	// reception state machine
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			rx_state <= card_pkg::RX_IDLE;
			multi <= 1'b0;
			bit_cnt <= '0;
			shreg <= '0;
		end else begin
			if (accept) begin
				shreg <= next_shreg;
			end
			case (rx_state)
				card_pkg::RX_IDLE: begin
					// a write command opens a transfer
					if (WR_START_I) begin
						rx_state <= card_pkg::RX_RECV;
						multi <= MULTI_BLOCK_I;
						bit_cnt <= '0;
					end
				end
				card_pkg::RX_RECV: begin
					if (STOP_I) begin
						rx_state <= card_pkg::RX_IDLE;
						bit_cnt <= '0;
					end else if (block_done) begin
						bit_cnt <= '0;
						if (!multi) begin
							rx_state <= card_pkg::RX_IDLE;
						end
					end else if (accept) begin
						bit_cnt <= next_cnt;
					end
				end
				default: begin
					rx_state <= card_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// programming engine and buffer count
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			prog_state <= card_pkg::PROG_IDLE;
			prog_cnt <= '0;
			bufs_used <= '0;
		end else begin
			bufs_used <= next_bufs;
			case (prog_state)
				card_pkg::PROG_IDLE: begin
					// oldest full buffer starts programming
					if (bufs_used != '0) begin
						prog_state <= card_pkg::PROG_RUN;
						prog_cnt <= PROG_LAST;
					end
				end
				card_pkg::PROG_RUN: begin
					if (prog_done) begin
						prog_state <= card_pkg::PROG_IDLE;
					end else begin
						prog_cnt <= prog_cnt - PCNT_W'(1);
					end
				end
				default: begin
					prog_state <= card_pkg::PROG_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin drivers and status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			push_pull <= 1'b0;
			SERIAL_OUT_O <= `CARD_LINE_IDLE;
			SERIAL_OUT_OE_O <= `CARD_OE_OFF;
			CMD_O <= `CARD_LINE_IDLE;
			CMD_OE_O <= `CARD_OE_OFF;
			DAT_O <= '0;
			DAT_OE_O <= '0;
			BUSY_O <= 1'b0;
			BLOCK_DONE_O <= 1'b0;
			PROG_DONE_O <= 1'b0;
			RX_BYTE_VALID_O <= 1'b0;
			RX_BYTE_O <= '0;
			CMD_RX_O <= `CARD_LINE_IDLE;
		end else begin
			if (INIT_DONE_I) begin
				push_pull <= 1'b1;
			end
			// open-drain only ever pulls low; push-pull drives both levels
			CMD_O <= CMD_TX_BIT_I;
			CMD_OE_O <= CMD_TX_EN_I & (push_pull | ~CMD_TX_BIT_I);
			// spi: output driven only while selected, low while busy
			SERIAL_OUT_O <= ~busy_cond;
			SERIAL_OUT_OE_O <= selected;
			// native: busy pulls data line 0 low, released otherwise
			DAT_O <= '0;
			DAT_OE_O <= {{(`CARD_DAT_WIDTH-1){`CARD_OE_OFF}}, busy_cond & ~mode_spi};
			BUSY_O <= busy_cond;
			BLOCK_DONE_O <= block_done;
			PROG_DONE_O <= prog_done;
			RX_BYTE_VALID_O <= byte_done;
			if (byte_done) begin
				RX_BYTE_O <= next_shreg;
			end
			CMD_RX_O <= cmd_s;
		end
	end

	assign PUSH_PULL_O = push_pull;
	assign RECEIVING_O = (rx_state == card_pkg::RX_RECV);
	assign BUFS_USED_O = bufs_used;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence single_end_s;
		block_done && !multi ##1 bufs_used != '0;
	endsequence

	open_drain_a: assert property (CMD_OE_O && !PUSH_PULL_O |-> !CMD_O)
		else $error("command line driven high before initialization");
	spi_select_a: assert property (mode_spi && sel_n_s |=> !SERIAL_OUT_OE_O && DAT_OE_O == '0)
		else $error("spi output driven while deselected");
	turnaround_a: assert property (DAT_OE_O != '0 |-> DAT_O == '0 && !SERIAL_OUT_OE_O)
		else $error("data line driven other than busy low");
	single_stop_a: assert property (block_done && !multi && !STOP_I |=> rx_state == card_pkg::RX_IDLE)
		else $error("single block transfer did not end");
	multi_run_a: assert property (multi && rx_state == card_pkg::RX_RECV && !STOP_I
		|=> rx_state == card_pkg::RX_RECV)
		else $error("multi block transfer ended without stop");
	multi_free_a: assert property (multi && rx_state == card_pkg::RX_RECV && bufs_used < BUFS_FULL
		|=> !BUSY_O)
		else $error("busy shown with a free buffer");
	single_busy_a: assert property (single_end_s |=> BUSY_O && (mode_spi || DAT_OE_O[0]))
		else $error("single block busy not shown");
	busy_hold_a: assert property (!multi && bufs_used != '0 && rx_state == card_pkg::RX_IDLE
		##1 bufs_used != '0 |-> BUSY_O)
		else $error("busy released before programming ended");

endmodule // card_bus_engine

// ### rtl/card_pkg.sv
// types shared by the card-side bus and write-buffer engine
package card_pkg;

	// ----------------------------------------------------------------
	// bus modes selected by the card's own front end
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SPI = 2'b00,
		MODE_NAT1 = 2'b01,
		MODE_NAT4 = 2'b10
	} bus_mode_t;

	// ----------------------------------------------------------------
	// state machines
	// ----------------------------------------------------------------
	typedef enum logic {
		RX_IDLE = 1'b0,
		RX_RECV = 1'b1
	} rx_state_t;

	typedef enum logic {
		PROG_IDLE = 1'b0,
		PROG_RUN = 1'b1
	} prog_state_t;

endpackage

// ### rtl/card_regs.svh
// constants for the card-side bus and write-buffer engine
`ifndef CARD_REGS_SVH
`define CARD_REGS_SVH

// ----------------------------------------------------------------
// data path geometry
// ----------------------------------------------------------------
`define CARD_DAT_WIDTH 4
`define CARD_BYTE_BITS 8
`define CARD_STEP_1BIT 1
`define CARD_STEP_4BIT 4
`define CARD_SYNC_WIDTH 8

// ----------------------------------------------------------------
// defaults of module parameters
// ----------------------------------------------------------------
`define CARD_BLOCK_BYTES 512
`define CARD_NUM_BUFS 2
`define CARD_PROG_CYCLES 64

// ----------------------------------------------------------------
// reset values of pin drivers
// ----------------------------------------------------------------
`define CARD_LINE_IDLE 1'b1
`define CARD_LINE_LOW 1'b0
`define CARD_OE_OFF 1'b0

`endif
